// [ipk_pkg.sv]
// Purpose: shared constants and types of the interrupt priority and edge test block
// Assumes: 8-bit register port, one clock
// Notes:   source index 0 has the highest default precedence
package ipk_pkg;

    localparam int NSRC = 5;
    localparam int NKEY = 8;

    // request source indices, in default precedence order
    localparam logic [2:0] SRC_BT   = 3'h0;
    localparam logic [2:0] SRC_EXT4 = 3'h1;
    localparam logic [2:0] SRC_EXT0 = 3'h2;
    localparam logic [2:0] SRC_CSI  = 3'h3;
    localparam logic [2:0] SRC_T0   = 3'h4;

    // register offsets
    localparam logic [3:0] A_REQ  = 4'h0;
    localparam logic [3:0] A_EN   = 4'h1;
    localparam logic [3:0] A_CTRL = 4'h2;
    localparam logic [3:0] A_STAT = 4'h3;
    localparam logic [3:0] A_RET  = 4'h4;
    localparam logic [3:0] A_ESEL = 4'h5;
    localparam logic [3:0] A_TEST = 4'h6;
    localparam logic [3:0] A_IST  = 4'h7;
    localparam logic [3:0] A_IMSK = 4'h8;

    // field positions
    localparam int CTRL_IME  = 0;
    localparam int CTRL_HPV  = 1;
    localparam int CTRL_HPLO = 2;
    localparam int TEST_REQ  = 0;
    localparam int TEST_EN   = 1;
    localparam int EV_TAKE   = 0;
    localparam int EV_EDGE   = 1;

    // reset values
    localparam logic [4:0] RST_REQ  = 5'h00;
    localparam logic [4:0] RST_EN   = 5'h00;
    localparam logic [4:0] RST_CTRL = 5'h00;
    localparam logic [3:0] RST_ESEL = 4'h0;
    localparam logic [1:0] RST_EV   = 2'h0;

    // in-service level, gray along 0 -> 1 -> 2
    typedef enum logic [1:0] {
        LVL0 = 2'b00,
        LVL1 = 2'b01,
        LVL2 = 2'b11
    } ipk_lvl_t;

    // arbitration result
    typedef struct packed {
        logic       take;
        logic [2:0] id;
        logic       hp;
    } ipk_grant_t;

endpackage

// [ipk_sync.sv]
// Purpose: two-stage synchroniser with one previous sample per bit
// Assumes: inputs asynchronous to clk
// Notes:   the first stage feeds only the second stage
`timescale 1ns/1ps
`default_nettype none
module ipk_sync #(
    parameter int W = 1
) (
    input  wire logic         clk,
    input  wire logic         rst_n,
    input  wire logic [W-1:0] din,
    output logic      [W-1:0] dsync,
    output logic      [W-1:0] dprev
);
    logic [W-1:0] meta_ff;
    logic [W-1:0] sync_ff;
    logic [W-1:0] prev_ff;

    ////////////////////////////////////////////////////////////////
    // two flops then one history flop per bit
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            meta_ff <= '0;
            sync_ff <= '0;
            prev_ff <= '0;
        end else begin
            meta_ff <= din;
            sync_ff <= meta_ff;
            prev_ff <= sync_ff;
        end
    end

    assign dsync = sync_ff;
    assign dprev = prev_ff;
endmodule
`default_nettype wire

// [ipk_arb.sv]
// Purpose: picks the request to service from pending flags and nesting state
// Assumes: pending already gated by enables and master enable
// Notes:   purely combinational
`timescale 1ns/1ps
`default_nettype none
module ipk_arb
    import ipk_pkg::*;
(
    input  wire logic [NSRC-1:0] pending,
    input  wire logic            hp_valid,
    input  wire logic [2:0]      hp_idx,
    input  wire ipk_lvl_t        level,
    input  wire logic            hp_run,
    output ipk_grant_t           grant
);
    logic [NSRC-1:0] hp_mask;
    logic [NSRC-1:0] allowed;
    logic [NSRC-1:0] hp_pend;

    ////////////////////////////////////////////////////////////////
    // one-hot of the designated source
    genvar g;
    generate
        for (g = 0; g < NSRC; g++) begin : g_hp
            assign hp_mask[g] = hp_valid && (hp_idx == 3'(g));
        end
    endgenerate

    // level 0 takes all, level 1 under a lower routine only the designated one
    assign allowed = (level == LVL0) ? pending :
                     (level == LVL1 && !hp_run) ? (pending & hp_mask) : '0;
    assign hp_pend = allowed & hp_mask;

    // designated source first, then lowest index
    always_comb begin
        grant = '0;
        if (|hp_pend) begin
            grant.take = 1'b1;
            grant.id   = hp_idx;
            grant.hp   = 1'b1;
        end else begin
            for (int i = NSRC - 1; i >= 0; i--) begin
                if (allowed[i]) begin
                    grant.take = 1'b1;
                    grant.id   = 3'(i);
                end
            end
        end
    end
endmodule
`default_nettype wire

// [ipk_top.sv]
// Purpose: interrupt acceptance, precedence, nesting and the edge test source
// Assumes: peripheral request pulses on clk; edge and key pins asynchronous
// Notes:   register port answers reads one cycle later, never stalls
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - priority select names one higher source; same write may set master enable.
// - taking a lower request raises level to 1, only higher source may nest.
// - higher source during level 1 nests, level becomes 2, all blocked.
// - return command lowers the in-service level by one.
// - software clearing the low status bit drops level 1 to 0.
// - flags set while disabled stay pending until master enable returns.
// - simultaneous lower requests: higher precedence first, other stays pending.
// - lower request during higher routine waits pending.
// - after higher routine, pending served in precedence order, serial before timer.
// - edge test flag set by hardware, cleared only by software write.
// - standby release only while edge test flag and its enable are both 1.
// - edge test flag from edge pin rising or key falling, by select.
// - in key mode select picks keys; falling edge on any sets flag.
// - edge select is 4 bits, whole-nibble write, resets to pin rising mode.
// - while a selected key is low, other key falls do not set flag.
// - software-set request flag behaves as a hardware-set one, but loses to a same-cycle accept.
module ipk_top
    import ipk_pkg::*;
(
    input  wire logic            clk,
    input  wire logic            rst_n,
    input  wire logic [3:0]      reg_addr,
    input  wire logic [7:0]      reg_wdata,
    input  wire logic            reg_wr,
    input  wire logic            reg_rd,
    output logic      [7:0]      reg_rdata,
    input  wire logic [NSRC-1:0] hw_req,
    input  wire logic            edge_pin,
    input  wire logic [NKEY-1:0] key_pins,
    output logic                 service_take,
    output logic      [2:0]      service_id,
    output logic      [1:0]      in_service_level,
    output logic                 standby_release,
    output logic                 irq
);
    logic [NSRC-1:0] req_ff;
    logic [NSRC-1:0] nxt_req;
    logic [NSRC-1:0] en_ff;
    logic [4:0]      ctrl_ff;
    logic [4:0]      nxt_ctrl;
    logic [3:0]      esel_ff;
    logic [3:0]      nxt_esel;
    logic            treq_ff;
    logic            nxt_treq;
    logic            ten_ff;
    ipk_lvl_t        lvl_ff;
    ipk_lvl_t        nxt_lvl;
    logic            hp_run_ff;
    logic            hp_low_ff;
    logic            nxt_hp_run;
    logic            nxt_hp_low;
    logic [1:0]      ev_ff;
    logic [1:0]      nxt_ev;
    logic [1:0]      imsk_ff;
    logic [7:0]      rdata_ff;
    logic [7:0]      nxt_rdata;
    logic            take_ff;
    logic [2:0]      id_ff;
    logic            rel_ff;
    logic            irq_ff;
    logic [1:0]      lvl_num;

    ////////////////////////////////////////////////////////////////
    // address decode
    wire wr_req  = reg_wr && (reg_addr == A_REQ);
    wire wr_en   = reg_wr && (reg_addr == A_EN);
    wire wr_ctrl = reg_wr && (reg_addr == A_CTRL);
    wire wr_stat = reg_wr && (reg_addr == A_STAT);
    wire wr_ret  = reg_wr && (reg_addr == A_RET);
    wire wr_esel = reg_wr && (reg_addr == A_ESEL);
    wire wr_test = reg_wr && (reg_addr == A_TEST);
    wire wr_imsk = reg_wr && (reg_addr == A_IMSK);
    wire rd_ist  = reg_rd && (reg_addr == A_IST);

    ////////////////////////////////////////////////////////////////
    // pin synchronisers and edge detection
    logic            pin_s;
    logic            pin_p;
    logic [NKEY-1:0] key_s;
    logic [NKEY-1:0] key_p;

    ipk_sync #(.W(1)) u_pin_sync (
        .clk   (clk),
        .rst_n (rst_n),
        .din   (edge_pin),
        .dsync (pin_s),
        .dprev (pin_p)
    );

    ipk_sync #(.W(NKEY)) u_key_sync (
        .clk   (clk),
        .rst_n (rst_n),
        .din   (key_pins),
        .dsync (key_s),
        .dprev (key_p)
    );

    // key selection: value n picks keys 0..n-1, 8 or more picks all
    logic [NKEY-1:0] key_sel;
    genvar k;
    generate
        for (k = 0; k < NKEY; k++) begin : g_ksel
            assign key_sel[k] = (esel_ff > 4'(k));
        end
    endgenerate

    // selected keys combine as a wired-and, so a held low masks others
    wire key_and_now  = &(key_s | ~key_sel);
    wire key_and_prev = &(key_p | ~key_sel);
    wire key_mode     = (esel_ff != RST_ESEL);
    wire pin_rise     = pin_s && !pin_p;
    wire key_fall     = key_and_prev && !key_and_now;
    wire test_set     = key_mode ? key_fall : pin_rise;

    ////////////////////////////////////////////////////////////////
    // arbitration
    wire             ime      = ctrl_ff[CTRL_IME];
    wire             hp_valid = ctrl_ff[CTRL_HPV];
    wire [2:0]       hp_idx   = ctrl_ff[CTRL_HPLO +: 3];
    // no accept in a cycle that returns or clears status, so that
    // neither level step is lost under a fresh accept
    wire             lvl_step = wr_ret || wr_stat;
    wire [NSRC-1:0]  pending  = (ime && !lvl_step) ? (req_ff & en_ff) : '0;
    ipk_grant_t      grant;

    ipk_arb u_arb (
        .pending  (pending),
        .hp_valid (hp_valid),
        .hp_idx   (hp_idx),
        .level    (lvl_ff),
        .hp_run   (hp_run_ff),
        .grant    (grant)
    );

    // a grant acks its own flag; a hardware set in the same cycle wins
    wire [NSRC-1:0] ack = grant.take ? (NSRC'(1) << grant.id) : '0;
    wire [NSRC-1:0] req_base = wr_req ? reg_wdata[NSRC-1:0] : req_ff;

    always_comb begin
        nxt_req = (req_base & ~ack) | hw_req;
    end

    ////////////////////////////////////////////////////////////////
    // control register: master enable and designated source together
    always_comb begin
        nxt_ctrl = wr_ctrl ? reg_wdata[4:0] : ctrl_ff;
    end

    // edge select takes the whole nibble at once
    always_comb begin
        nxt_esel = wr_esel ? reg_wdata[3:0] : esel_ff;
    end

    // test flag: hardware only sets, software write may clear
    always_comb begin
        nxt_treq = (wr_test ? reg_wdata[TEST_REQ] : treq_ff) | test_set;
    end

    ////////////////////////////////////////////////////////////////
    // in-service level stepping
    always_comb begin
        nxt_lvl    = lvl_ff;
        nxt_hp_run = hp_run_ff;
        nxt_hp_low = hp_low_ff;
        if (grant.take) begin
            case (lvl_ff)
                LVL0: begin
                    nxt_lvl    = LVL1;
                    nxt_hp_run = grant.hp;
                    nxt_hp_low = 1'b0;
                end
                LVL1: begin
                    nxt_lvl    = LVL2;
                    nxt_hp_low = hp_run_ff;
                    nxt_hp_run = 1'b1;
                end
                default: begin
                    nxt_lvl = lvl_ff;
                end
            endcase
        end else if (wr_ret) begin
            case (lvl_ff)
                LVL2: begin
                    nxt_lvl    = LVL1;
                    nxt_hp_run = hp_low_ff;
                    nxt_hp_low = 1'b0;
                end
                LVL1: begin
                    nxt_lvl    = LVL0;
                    nxt_hp_run = 1'b0;
                end
                default: begin
                    nxt_lvl = LVL0;
                end
            endcase
        end else if (wr_stat && !reg_wdata[0] && lvl_ff == LVL1) begin
            nxt_lvl    = LVL0;
            nxt_hp_run = 1'b0;
        end
    end

    // numeric view of the level
    always_comb begin
        case (nxt_lvl)
            LVL0:    lvl_num = 2'h0;
            LVL1:    lvl_num = 2'h1;
            LVL2:    lvl_num = 2'h2;
            default: lvl_num = 2'h0;
        endcase
    end

    ////////////////////////////////////////////////////////////////
    // interrupt events: set wins over the read clear
    wire [1:0] ev_set = {test_set && !treq_ff, grant.take};

    always_comb begin
        nxt_ev = (rd_ist ? 2'h0 : ev_ff) | ev_set;
    end

    ////////////////////////////////////////////////////////////////
    // read mux
    always_comb begin
        nxt_rdata = 8'h00;
        if (reg_rd) begin
            case (reg_addr)
                A_REQ:   nxt_rdata = {3'h0, req_ff};
                A_EN:    nxt_rdata = {3'h0, en_ff};
                A_CTRL:  nxt_rdata = {3'h0, ctrl_ff};
                A_STAT:  nxt_rdata = {6'h00, in_service_level};
                A_ESEL:  nxt_rdata = {4'h0, esel_ff};
                A_TEST:  nxt_rdata = {6'h00, ten_ff, treq_ff};
                A_IST:   nxt_rdata = {6'h00, ev_ff};
                A_IMSK:  nxt_rdata = {6'h00, imsk_ff};
                default: nxt_rdata = 8'h00;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////
    // next values of the plain registers and of the output flops
    // one next value per register keeps the clocked blocks to plain copies
    logic [NSRC-1:0] nxt_en;
    logic            nxt_ten;
    logic [1:0]      nxt_imsk;
    logic [2:0]      nxt_id;
    logic            nxt_rel;
    logic            nxt_irq;

    assign nxt_en   = wr_en ? reg_wdata[NSRC-1:0] : en_ff;
    assign nxt_ten  = wr_test ? reg_wdata[TEST_EN] : ten_ff;
    assign nxt_imsk = wr_imsk ? reg_wdata[1:0] : imsk_ff;
    // service_id holds the last accepted source until the next accept
    assign nxt_id   = grant.take ? grant.id : id_ff;
    // release follows the flag and enable as they will be after this edge
    assign nxt_rel  = nxt_treq && nxt_ten;
    assign nxt_irq  = |(nxt_ev & imsk_ff);

    ////////////////////////////////////////////////////////////////
    // request, enable and control state
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            req_ff  <= RST_REQ;
            en_ff   <= RST_EN;
            ctrl_ff <= RST_CTRL;
            esel_ff <= RST_ESEL;
        end else begin
            req_ff  <= nxt_req;
            en_ff   <= nxt_en;
            ctrl_ff <= nxt_ctrl;
            esel_ff <= nxt_esel;
        end
    end

    // edge test source state
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            treq_ff <= 1'b0;
            ten_ff  <= 1'b0;
        end else begin
            treq_ff <= nxt_treq;
            ten_ff  <= nxt_ten;
        end
    end

    // nesting state
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            lvl_ff    <= LVL0;
            hp_run_ff <= 1'b0;
            hp_low_ff <= 1'b0;
        end else begin
            lvl_ff    <= nxt_lvl;
            hp_run_ff <= nxt_hp_run;
            hp_low_ff <= nxt_hp_low;
        end
    end

    // status and mask of the interrupt output
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ev_ff   <= RST_EV;
            imsk_ff <= RST_EV;
        end else begin
            ev_ff   <= nxt_ev;
            imsk_ff <= nxt_imsk;
        end
    end

    ////////////////////////////////////////////////////////////////
    // registered outputs
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rdata_ff         <= 8'h00;
            take_ff          <= 1'b0;
            id_ff            <= 3'h0;
            in_service_level <= 2'h0;
            rel_ff           <= 1'b0;
            irq_ff           <= 1'b0;
        end else begin
            rdata_ff         <= nxt_rdata;
            take_ff          <= grant.take;
            id_ff            <= nxt_id;
            in_service_level <= lvl_num;
            rel_ff           <= nxt_rel;
            irq_ff           <= nxt_irq;
        end
    end

    assign reg_rdata       = rdata_ff;
    assign service_take    = take_ff;
    assign service_id      = id_ff;
    assign standby_release = rel_ff;
    assign irq             = irq_ff;
endmodule
`default_nettype wire

// [ipk_monitor.sv]
// Purpose: port-level checks of nesting, return, status clear and edge test release
// Assumes: one clock, synchronous active-low reset
// Notes:   bound to ipk_top after the module
`timescale 1ns/1ps
`default_nettype none
module ipk_monitor
    import ipk_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic [3:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    input  wire logic [7:0] reg_rdata,
    input  wire logic       service_take,
    input  wire logic [1:0] in_service_level,
    input  wire logic       standby_release
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);

    ////////////////////////////////////////////////////////////////////////////////
    // software steps that move the level down
    sequence ret_wr;
        reg_wr && reg_addr == A_RET && in_service_level != 2'h0;
    endsequence
    sequence stat_wr;
        reg_wr && reg_addr == A_STAT && !reg_wdata[0] && in_service_level == 2'h1;
    endsequence

    ////////////////////////////////////////////////////////////////////////////////
    // level bookkeeping
    take_raise_a: assert property (
        service_take |-> in_service_level == $past(in_service_level) + 2'h1)
        else $error("level not raised by one on accept");
    level_range_a: assert property (
        in_service_level != 2'h3)
        else $error("level above two");
    full_block_a: assert property (
        in_service_level == 2'h2 |=> !service_take)
        else $error("accept while at level two");
    return_drop_a: assert property (
        ret_wr |=> service_take || in_service_level == $past(in_service_level) - 2'h1)
        else $error("return did not lower level by one");
    status_clear_a: assert property (
        stat_wr |=> service_take || in_service_level == 2'h0)
        else $error("status clear did not drop level");
    level_hold_a: assert property (
        in_service_level != $past(in_service_level) |-> service_take || $past(reg_wr))
        else $error("level moved without cause");

    ////////////////////////////////////////////////////////////////////////////////
    // edge test release and register port
    sticky_flag_a: assert property (
        $fell(standby_release) |-> $past(reg_wr && reg_addr == A_TEST))
        else $error("release dropped without software write");
    select_width_a: assert property (
        $past(reg_rd) && $past(reg_addr) == A_ESEL |-> reg_rdata[7:4] == 4'h0)
        else $error("edge select wider than a nibble");
    read_idle_a: assert property (
        !$past(reg_rd) |-> reg_rdata == 8'h00)
        else $error("read data outside read cycle");
endmodule

bind ipk_top ipk_monitor ipk_monitor_inst (
    .clk              (clk),
    .rst_n            (rst_n),
    .reg_addr         (reg_addr),
    .reg_wdata        (reg_wdata),
    .reg_wr           (reg_wr),
    .reg_rd           (reg_rd),
    .reg_rdata        (reg_rdata),
    .service_take     (service_take),
    .in_service_level (in_service_level),
    .standby_release  (standby_release)
);
`default_nettype wire

// [ipk_pins_model.sv]
// Purpose: edge pin and key-return pins seen from outside the device
// Assumes: keys pulled up, pressed key pulls low
// Notes:   pins move a skew after the command, unrelated to the clock edge
`timescale 1ns/1ps
`default_nettype none
module ipk_pins_model #(
    parameter int SKEW_NS = 13
) (
    input  wire logic       edge_lvl,
    input  wire logic [7:0] key_hold,
    output var  logic       edge_pin,
    output var  logic [7:0] key_pins
);
    // idle levels: edge pin low, keys released
    initial begin
        edge_pin = 1'b0;
        key_pins = 8'hFF;
    end
    // edge pin follows its command late, off the sampling edge
    always @(edge_lvl) edge_pin <= #SKEW_NS edge_lvl;
    // a released key returns to the pull-up level
    always @(key_hold) key_pins <= #SKEW_NS ~key_hold;
endmodule
`default_nettype wire

// [tb_top.sv]
// Purpose: register-driven tests of acceptance, nesting and the edge test source
// Assumes: 20 MHz clock, reset held six cycles
// Notes:   expectations follow the offsets and source indices of the package
`timescale 1ns/1ps
`default_nettype none
module tb_top
    import ipk_pkg::*;
;
    logic       clk, rst_n, reg_wr, reg_rd, edge_lvl, edge_pin;
    logic [3:0] reg_addr;
    logic [7:0] reg_wdata, reg_rdata, key_pins, key_hold;
    logic [4:0] hw_req;
    logic       service_take, standby_release, irq;
    logic [2:0] service_id;
    logic [1:0] in_service_level;
    int         errors, checks;

    ////////////////////////////////////////////////////////////////////////////////
    // clock, design and pins
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    ipk_top ipk_top_inst (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .hw_req(hw_req), .edge_pin(edge_pin), .key_pins(key_pins),
        .service_take(service_take), .service_id(service_id),
        .in_service_level(in_service_level), .standby_release(standby_release), .irq(irq));
    ipk_pins_model ipk_pins_model_inst (.edge_lvl(edge_lvl), .key_hold(key_hold),
        .edge_pin(edge_pin), .key_pins(key_pins));

    ////////////////////////////////////////////////////////////////////////////////
    // shared tasks
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp) begin
            errors++;
            $display("wrong value at %0t ns: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, input logic [7:0] exp);
        @(posedge clk);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 chk(reg_rdata, exp);
    endtask
    task automatic pulse(input logic [4:0] m);
        @(posedge clk);
        hw_req <= m;
        @(posedge clk);
        hw_req <= 5'h00;
    endtask
    task automatic take(input logic [2:0] id, input logic [1:0] lv);
        int i;
        for (i = 0; i < 12 && service_take !== 1'b1; i++) begin
            @(posedge clk);
            #1;
        end
        chk({7'h00, service_take}, 8'h01);
        chk({5'h00, service_id}, {5'h00, id});
        chk({6'h00, in_service_level}, {6'h00, lv});
    endtask
    task automatic quiet(input int n);
        repeat (n) begin
            @(posedge clk);
            #1 chk({7'h00, service_take}, 8'h00);
        end
    endtask
    task automatic keys(input logic [7:0] m);
        @(posedge clk);
        key_hold <= m;
        repeat (8) @(posedge clk);
    endtask
    task automatic report_and_stop;
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // watchdog against a hang
    initial begin
        repeat (5000) @(posedge clk);
        errors++;
        report_and_stop;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // test sequence
    initial begin
        {rst_n, reg_wr, reg_rd, edge_lvl} = 4'h0;
        {reg_addr, reg_wdata, hw_req, key_hold} = 25'h0;
        {errors, checks} = 64'h0;
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        rd(A_ESEL, 8'h00);
        rd(A_CTRL, 8'h00);
        rd(4'hF, 8'h00);
        wr(A_EN, 8'h1F);
        // pending while disabled, irq masked then unmasked
        pulse(5'h04);
        quiet(6);
        rd(A_REQ, 8'h04);
        wr(A_CTRL, 8'h01);
        take(SRC_EXT0, 2'h1);
        chk({7'h00, irq}, 8'h00);
        wr(A_IMSK, 8'h01);
        repeat (2) @(posedge clk);
        #1 chk({7'h00, irq}, 8'h01);
        rd(A_IST, 8'h01);
        repeat (2) @(posedge clk);
        #1 chk({7'h00, irq}, 8'h00);
        wr(A_RET, 8'h00);
        rd(A_STAT, 8'h00);
        // two lower requests in one cycle
        pulse(5'h14);
        take(SRC_EXT0, 2'h1);
        quiet(4);
        rd(A_REQ, 8'h10);
        wr(A_RET, 8'h00);
        take(SRC_T0, 2'h1);
        wr(A_RET, 8'h00);
        // designated source nests over a lower routine
        wr(A_CTRL, {3'h0, SRC_BT, 2'h3});
        wr(A_REQ, 8'h10);
        take(SRC_T0, 2'h1);
        pulse(5'h08);
        quiet(6);
        pulse(5'h01);
        take(SRC_BT, 2'h2);
        pulse(5'h02);
        quiet(6);
        wr(A_RET, 8'h00);
        rd(A_STAT, 8'h01);
        wr(A_RET, 8'h00);
        take(SRC_EXT4, 2'h1);
        wr(A_RET, 8'h00);
        take(SRC_CSI, 2'h1);
        wr(A_RET, 8'h00);
        // lower requests wait behind the designated routine
        pulse(5'h01);
        take(SRC_BT, 2'h1);
        pulse(5'h18);
        quiet(6);
        wr(A_RET, 8'h00);
        take(SRC_CSI, 2'h1);
        wr(A_RET, 8'h00);
        take(SRC_T0, 2'h1);
        // clearing the low status bit reopens acceptance of lower requests
        wr(A_STAT, 8'h00);
        rd(A_STAT, 8'h00);
        pulse(5'h04);
        take(SRC_EXT0, 2'h1);
        wr(A_RET, 8'h00);
        // edge test source, pin mode then key mode
        wr(A_TEST, 8'h02);
        @(posedge clk);
        edge_lvl <= 1'b1;
        repeat (8) @(posedge clk);
        #1 chk({7'h00, standby_release}, 8'h01);
        rd(A_TEST, 8'h03);
        wr(A_TEST, 8'h01);
        rd(A_TEST, 8'h01);
        chk({7'h00, standby_release}, 8'h00);
        wr(A_ESEL, 8'h04);
        wr(A_TEST, 8'h00);
        wr(A_TEST, 8'h02);
        keys(8'h20);
        rd(A_TEST, 8'h02);
        keys(8'h22);
        rd(A_TEST, 8'h03);
        wr(A_TEST, 8'h02);
        keys(8'h26);
        rd(A_TEST, 8'h02);
        keys(8'h00);
        keys(8'h01);
        rd(A_TEST, 8'h03);
        wr(A_ESEL, 8'hFF);
        rd(A_ESEL, 8'h0F);
        report_and_stop;
    end
endmodule
`default_nettype wire
